// file: verilog/flash_cmd_pkg.sv
package flash_cmd_pkg;

  localparam int ADDR_W  = 18;
  localparam int DATA_W  = 8;
  localparam int N_SECT  = 7;

  // Command opcodes
  localparam logic [7:0] OP_READ_ARRAY   = 8'hff;
  localparam logic [7:0] OP_ERASE        = 8'h21;
  localparam logic [7:0] OP_UNIFORM      = 8'h20;
  localparam logic [7:0] OP_CONFIRM      = 8'hd0;
  localparam logic [7:0] OP_PROG_A       = 8'h40;
  localparam logic [7:0] OP_PROG_B       = 8'h10;
  localparam logic [7:0] OP_READ_STATUS  = 8'h70;
  localparam logic [7:0] OP_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] OP_READ_ID      = 8'h90;

  // Status bit positions
  localparam int SB_READY      = 7;
  localparam int SB_ERASE_FAIL = 5;
  localparam int SB_PROG_FAIL  = 4;
  localparam int SB_PROTECT    = 1;

  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ID_UNMAPPED = 8'h00;

  localparam logic [ADDR_W-1:0] ID_ADDR_MFR = 18'h00000;
  localparam logic [ADDR_W-1:0] ID_ADDR_DEV = 18'h00001;

  // Sector map, index 6 is the top boot sector
  localparam logic [N_SECT-1:0][ADDR_W-1:0] SECT_BASE = {
    18'h3c000, 18'h3a000, 18'h38000, 18'h30000, 18'h20000, 18'h10000, 18'h00000};
  localparam logic [N_SECT-1:0][ADDR_W-1:0] SECT_LAST = {
    18'h3ffff, 18'h3bfff, 18'h39fff, 18'h37fff, 18'h2ffff, 18'h1ffff, 18'h0ffff};
  localparam logic [2:0] FIRST_SUB = 3'h3;
  localparam logic [2:0] TOP_BOOT  = 3'h6;
  localparam logic [ADDR_W-1:0] SUB_BASE = 18'h30000;
  localparam logic [ADDR_W-1:0] SUB_LAST = 18'h3ffff;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS  = 20000;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FETCH_WAIT    = 1;

  typedef enum logic [2:0] {
    ST_IDLE       = 3'b000,
    ST_WAIT_ERASE = 3'b001,
    ST_ERASE_RUN  = 3'b011,
    ST_WAIT_PROG  = 3'b100,
    ST_PROG_FETCH = 3'b101,
    ST_PROG_PULSE = 3'b111,
    ST_PROG_WRITE = 3'b110
  } state_t;

  typedef enum logic [1:0] {
    RM_ARRAY  = 2'b00,
    RM_STATUS = 2'b01,
    RM_ID     = 2'b11
  } read_mode_t;

endpackage

// file: verilog/flash_erase_program_status.sv
// Summary of operation
// RL1: Program only clears bits, never sets them
// RL2: Erase needs two writes, then self-timed
// RL3: Uniform erase on sub-sector erases all four
// RL4: Standard erase erases the addressed sector only
// RL5: After erase or program, reads return status
// RL6: Erase needs lock clear and pin inactive
// RL7: Uniform sub-sector erase checks all locks, boot pin
// RL8: Erased bytes read all ones
// RL9: Program second write carries address and data
// RL10: Program pulse timed internally
// RL11: Protected program fails, memory untouched, flagged
// RL12: Status read command accepted at any time
// RL13: Error flags set by engine, cleared by command
// RL14: Bit 7 low while busy, high idle
// RL15: Bits 5,4 erase/program fail, both sequence error
// RL16: Bit 1 flags protected target sector
// RL17: Protect flag updated only on attempts
// RL18: Identification reads give maker, device codes
// RL19: Any valid command leaves identification mode
// RL20: Host clears status after error before retrying
// RL21: Program accepts opcode 40h or 10h
// RL22: Sectors 6 to 3 sub, 2 to 0 main
// RL23: Read array ignored while busy
// RL24: Reserved status bits read zero
`timescale 1ns/1ns
module flash_erase_program_status #(
  parameter int         PROG_CYCLES = flash_cmd_pkg::PROG_CYCLES,
  // Identity values are arbitrary
  parameter logic [7:0] MFR_ID      = 8'h5a,
  parameter logic [7:0] DEV_ID      = 8'hc3
) (
  input  wire logic                             clk_sys,
  input  wire logic                             rstn,
  input  wire logic                             cmd_wr,
  input  wire logic                             cmd_rd,
  input  wire logic [flash_cmd_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [flash_cmd_pkg::DATA_W-1:0] cmd_wdata,
  output logic      [flash_cmd_pkg::DATA_W-1:0] rd_data,
  output logic                                  rd_valid,
  input  wire logic [flash_cmd_pkg::N_SECT-1:0] lock_bits,
  input  wire logic                             top_boot_lock_pin_n,
  input  wire logic                             write_protect_pin_n,
  output logic                                  arr_rd,
  output logic                                  arr_we,
  output logic      [flash_cmd_pkg::ADDR_W-1:0] arr_addr,
  output logic      [flash_cmd_pkg::DATA_W-1:0] arr_wdata,
  input  wire logic [flash_cmd_pkg::DATA_W-1:0] arr_rdata,
  output logic                                  busy
);

  localparam int TMR_W = $clog2(PROG_CYCLES + 2);

  generate
    if (PROG_CYCLES < 1 || flash_cmd_pkg::ADDR_W != 18 || flash_cmd_pkg::DATA_W != 8) begin : g_chk
      $error("flash_erase_program_status: unsupported parameter values");
    end
    // The lock slice used for uniform erase assumes the seven-sector map
    if (flash_cmd_pkg::N_SECT != 7) begin : g_chk_map
      $error("flash_erase_program_status: sector map must hold seven sectors");
    end
  endgenerate

  flash_cmd_pkg::state_t                 state_q;
  flash_cmd_pkg::read_mode_t             mode_q;
  logic [TMR_W-1:0]                      tmr_q;
  logic [flash_cmd_pkg::ADDR_W-1:0]      er_last_q;
  logic [flash_cmd_pkg::DATA_W-1:0]      prog_data_q;
  logic                                  uniform_q;
  logic                                  erase_fail_q;
  logic                                  prog_fail_q;
  logic                                  protect_q;
  logic                                  rd_p1_q;
  logic                                  rd_p2_q;
  flash_cmd_pkg::read_mode_t             rd_mode_p1_q;
  flash_cmd_pkg::read_mode_t             rd_mode_p2_q;
  logic [flash_cmd_pkg::ADDR_W-1:0]      rd_addr_p1_q;
  logic [flash_cmd_pkg::ADDR_W-1:0]      rd_addr_p2_q;

  logic [2:0]                            sect;
  logic                                  sub_target;
  logic                                  erase_blocked;
  logic                                  prog_blocked;
  logic                                  wr_idle;
  logic                                  wr_busy;
  logic                                  erase_confirm;
  logic                                  erase_seq_err;
  logic                                  erase_prot;
  logic                                  prog_prot;
  logic                                  prog_start;
  logic                                  clr_status;
  logic                                  in_busy;
  logic [flash_cmd_pkg::DATA_W-1:0]      status_byte;

  function automatic logic [2:0] sector_of(input logic [flash_cmd_pkg::ADDR_W-1:0] a);
    logic [2:0] s;
    s = {1'b0, a[17:16]};
    for (int i = flash_cmd_pkg::N_SECT - 1; i >= 0; i--) begin
      if (a >= flash_cmd_pkg::SECT_BASE[i] && a <= flash_cmd_pkg::SECT_LAST[i]) begin
        s = 3'(i);
      end
    end
    return s;
  endfunction

  function automatic logic sect_protected(input logic [2:0] s);
    logic pin_on;
    pin_on = (s == flash_cmd_pkg::TOP_BOOT) ? !top_boot_lock_pin_n : !write_protect_pin_n;
    return lock_bits[s] | pin_on;
  endfunction

  assign sect       = sector_of(cmd_addr); // RL22
  assign sub_target = (sect >= flash_cmd_pkg::FIRST_SUB); // RL22
  assign in_busy    = (state_q == flash_cmd_pkg::ST_ERASE_RUN)
                   || (state_q == flash_cmd_pkg::ST_PROG_FETCH)
                   || (state_q == flash_cmd_pkg::ST_PROG_PULSE)
                   || (state_q == flash_cmd_pkg::ST_PROG_WRITE);

  // Uniform erase of the sub-sector region needs lock bits 6 to 3 clear and the boot pin inactive
  assign erase_blocked = (uniform_q && sub_target)
                       ? ((|lock_bits[6:3]) | !top_boot_lock_pin_n) // RL7
                       : sect_protected(sect); // RL6
  assign prog_blocked  = sect_protected(sect); // RL11

  assign wr_idle       = cmd_wr && (state_q == flash_cmd_pkg::ST_IDLE);
  assign wr_busy       = cmd_wr && in_busy;
  assign erase_confirm = cmd_wr && (state_q == flash_cmd_pkg::ST_WAIT_ERASE)
                      && (cmd_wdata == flash_cmd_pkg::OP_CONFIRM); // RL2
  assign erase_seq_err = cmd_wr && (state_q == flash_cmd_pkg::ST_WAIT_ERASE)
                      && (cmd_wdata != flash_cmd_pkg::OP_CONFIRM);
  assign erase_prot    = erase_confirm && erase_blocked;
  assign prog_prot     = cmd_wr && (state_q == flash_cmd_pkg::ST_WAIT_PROG) && prog_blocked;
  assign prog_start    = cmd_wr && (state_q == flash_cmd_pkg::ST_WAIT_PROG) && !prog_blocked;
  assign clr_status    = wr_idle && (cmd_wdata == flash_cmd_pkg::OP_CLEAR_STATUS);

  always_comb begin
    status_byte = 8'h00; // RL24
    status_byte[flash_cmd_pkg::SB_READY]      = !in_busy; // RL14
    status_byte[flash_cmd_pkg::SB_ERASE_FAIL] = erase_fail_q; // RL15
    status_byte[flash_cmd_pkg::SB_PROG_FAIL]  = prog_fail_q; // RL15
    status_byte[flash_cmd_pkg::SB_PROTECT]    = protect_q; // RL16
  end

  // Write engine and array port
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q     <= flash_cmd_pkg::ST_IDLE;
      tmr_q       <= '0;
      er_last_q   <= '0;
      prog_data_q <= '0;
      uniform_q   <= 1'b0;
      arr_rd      <= 1'b0;
      arr_we      <= 1'b0;
      arr_addr    <= '0;
      arr_wdata   <= '0;
      busy        <= 1'b0;
    end else begin
      arr_rd <= 1'b0;
      case (state_q)
        flash_cmd_pkg::ST_IDLE: begin
          if (cmd_rd && mode_q == flash_cmd_pkg::RM_ARRAY) begin
            arr_rd   <= 1'b1;
            arr_addr <= cmd_addr;
          end
          if (wr_idle) begin
            case (cmd_wdata)
              flash_cmd_pkg::OP_ERASE: begin
                uniform_q <= 1'b0; // RL4
                state_q   <= flash_cmd_pkg::ST_WAIT_ERASE; // RL2
              end
              flash_cmd_pkg::OP_UNIFORM: begin
                uniform_q <= 1'b1; // RL3
                state_q   <= flash_cmd_pkg::ST_WAIT_ERASE; // RL2
              end
              flash_cmd_pkg::OP_PROG_A, flash_cmd_pkg::OP_PROG_B: begin
                state_q <= flash_cmd_pkg::ST_WAIT_PROG; // RL21
              end
              default: begin
              end
            endcase
          end
        end
        flash_cmd_pkg::ST_WAIT_ERASE: begin
          if (cmd_rd && mode_q == flash_cmd_pkg::RM_ARRAY) begin
            arr_rd   <= 1'b1;
            arr_addr <= cmd_addr;
          end
          if (erase_confirm && !erase_blocked) begin
            state_q   <= flash_cmd_pkg::ST_ERASE_RUN;
            busy      <= 1'b1;
            arr_we    <= 1'b1;
            arr_wdata <= flash_cmd_pkg::ERASED_BYTE; // RL8
            if (uniform_q && sub_target) begin
              arr_addr  <= flash_cmd_pkg::SUB_BASE; // RL3
              er_last_q <= flash_cmd_pkg::SUB_LAST; // RL3
            end else begin
              arr_addr  <= flash_cmd_pkg::SECT_BASE[sect]; // RL4
              er_last_q <= flash_cmd_pkg::SECT_LAST[sect]; // RL4
            end
          end else if (cmd_wr) begin
            state_q <= flash_cmd_pkg::ST_IDLE;
          end
        end
        flash_cmd_pkg::ST_ERASE_RUN: begin
          // One byte per cycle; the walk itself is the erase timer
          if (arr_addr == er_last_q) begin
            arr_we  <= 1'b0;
            busy    <= 1'b0;
            state_q <= flash_cmd_pkg::ST_IDLE;
          end else begin
            arr_addr <= arr_addr + 1'b1; // RL2
          end
        end
        flash_cmd_pkg::ST_WAIT_PROG: begin
          if (cmd_rd && mode_q == flash_cmd_pkg::RM_ARRAY) begin
            arr_rd   <= 1'b1;
            arr_addr <= cmd_addr;
          end
          if (prog_start) begin
            arr_rd      <= 1'b1;
            arr_addr    <= cmd_addr; // RL9
            prog_data_q <= cmd_wdata; // RL9
            tmr_q       <= TMR_W'(flash_cmd_pkg::FETCH_WAIT);
            busy        <= 1'b1;
            state_q     <= flash_cmd_pkg::ST_PROG_FETCH;
          end else if (prog_prot) begin
            state_q <= flash_cmd_pkg::ST_IDLE; // RL11
          end
        end
        flash_cmd_pkg::ST_PROG_FETCH: begin
          if (tmr_q == '0) begin
            // Merge with the stored byte so no bit can rise
            prog_data_q <= prog_data_q & arr_rdata; // RL1
            tmr_q       <= TMR_W'(PROG_CYCLES - 1);
            state_q     <= flash_cmd_pkg::ST_PROG_PULSE;
          end else begin
            tmr_q <= tmr_q - 1'b1;
          end
        end
        flash_cmd_pkg::ST_PROG_PULSE: begin
          if (tmr_q == '0) begin
            arr_we    <= 1'b1;
            arr_wdata <= prog_data_q; // RL1
            state_q   <= flash_cmd_pkg::ST_PROG_WRITE;
          end else begin
            tmr_q <= tmr_q - 1'b1; // RL10
          end
        end
        flash_cmd_pkg::ST_PROG_WRITE: begin
          arr_we  <= 1'b0;
          busy    <= 1'b0;
          state_q <= flash_cmd_pkg::ST_IDLE;
        end
        default: begin
          arr_we  <= 1'b0;
          busy    <= 1'b0;
          state_q <= flash_cmd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Error flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      erase_fail_q <= 1'b0;
      prog_fail_q  <= 1'b0;
      protect_q    <= 1'b0;
    end else begin
      erase_fail_q <= (erase_prot | erase_seq_err) | (erase_fail_q & !clr_status); // RL13
      prog_fail_q  <= (prog_prot | erase_seq_err) | (prog_fail_q & !clr_status); // RL15
      protect_q    <= (erase_prot | prog_prot) | (protect_q & !clr_status); // RL17
    end
  end

  // Read mode selection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_q <= flash_cmd_pkg::RM_ARRAY;
    // While the engine runs only the status command is acted on
    end else if (wr_busy) begin // RL23
      if (cmd_wdata == flash_cmd_pkg::OP_READ_STATUS) begin
        mode_q <= flash_cmd_pkg::RM_STATUS; // RL12
      end
    end else if (wr_idle) begin
      case (cmd_wdata) // RL19
        flash_cmd_pkg::OP_READ_ARRAY:  mode_q <= flash_cmd_pkg::RM_ARRAY; // RL23
        flash_cmd_pkg::OP_READ_STATUS: mode_q <= flash_cmd_pkg::RM_STATUS; // RL12
        flash_cmd_pkg::OP_READ_ID:     mode_q <= flash_cmd_pkg::RM_ID; // RL18
        flash_cmd_pkg::OP_CLEAR_STATUS,
        flash_cmd_pkg::OP_ERASE,
        flash_cmd_pkg::OP_UNIFORM,
        flash_cmd_pkg::OP_PROG_A,
        flash_cmd_pkg::OP_PROG_B:      mode_q <= (mode_q == flash_cmd_pkg::RM_ID)
                                                 ? flash_cmd_pkg::RM_ARRAY : mode_q; // RL19
        default:                       mode_q <= mode_q;
      endcase
    end else if (cmd_wr && (state_q == flash_cmd_pkg::ST_WAIT_ERASE
                         || state_q == flash_cmd_pkg::ST_WAIT_PROG)) begin
      mode_q <= flash_cmd_pkg::RM_STATUS; // RL5
    end
  end

  // Read pipeline: three edges, matching the array read latency
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_p1_q      <= 1'b0;
      rd_p2_q      <= 1'b0;
      rd_mode_p1_q <= flash_cmd_pkg::RM_ARRAY;
      rd_mode_p2_q <= flash_cmd_pkg::RM_ARRAY;
      rd_addr_p1_q <= '0;
      rd_addr_p2_q <= '0;
      rd_valid     <= 1'b0;
      rd_data      <= '0;
    end else begin
      rd_p1_q      <= cmd_rd;
      rd_p2_q      <= rd_p1_q;
      rd_mode_p1_q <= cmd_rd ? mode_q : rd_mode_p1_q;
      rd_mode_p2_q <= rd_mode_p1_q;
      rd_addr_p1_q <= cmd_rd ? cmd_addr : rd_addr_p1_q;
      rd_addr_p2_q <= rd_addr_p1_q;
      rd_valid     <= rd_p2_q;
      if (rd_p2_q) begin
        case (rd_mode_p2_q)
          flash_cmd_pkg::RM_ARRAY:  rd_data <= arr_rdata;
          flash_cmd_pkg::RM_STATUS: rd_data <= status_byte; // RL5
          flash_cmd_pkg::RM_ID: begin
            if (rd_addr_p2_q == flash_cmd_pkg::ID_ADDR_MFR) begin
              rd_data <= MFR_ID; // RL18
            end else if (rd_addr_p2_q == flash_cmd_pkg::ID_ADDR_DEV) begin
              rd_data <= DEV_ID; // RL18
            end else begin
              rd_data <= flash_cmd_pkg::ID_UNMAPPED;
            end
          end
          default: rd_data <= status_byte;
        endcase
      end
    end
  end

endmodule // flash_erase_program_status

// file: testbench/flash_status_asserts.sv
`timescale 1ns/1ns
module flash_status_checker #(
  parameter int PROG_CYCLES = 4
) (
  input wire logic                             clk_sys,
  input wire logic                             rstn,
  input wire logic                             cmd_wr,
  input wire logic                             cmd_rd,
  input wire logic                             rd_valid,
  input wire logic                             busy,
  input wire logic                             arr_rd,
  input wire logic                             arr_we,
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] arr_addr,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] arr_wdata,
  input wire logic [flash_cmd_pkg::DATA_W-1:0] arr_rdata
);
  localparam int PROG_MAX = PROG_CYCLES + 6;
  logic       seen_q;
  logic [7:0] old_q;
  // Old byte arrives one cycle after the array strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) seen_q <= 1'b0;
    else seen_q <= arr_rd;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) old_q <= 8'h00;
    else if (seen_q) old_q <= arr_rdata;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_read_latency: assert property (cmd_rd |-> ##3 rd_valid)
    else $error("read not answered after three cycles");
  a_valid_cause: assert property (rd_valid |-> $past(cmd_rd, 3))
    else $error("read answer without a request");
  a_busy_start: assert property ($rose(busy) |-> $past(cmd_wr))
    else $error("busy rose without a second command cycle");
  a_prog_self_timed: assert property (arr_rd && busy |-> (!arr_we)[*5] ##[1:PROG_MAX] arr_we)
    else $error("program write not timed internally");
  a_prog_clear_only: assert property ((arr_we && !$past(arr_we)) ##1 !arr_we
    |-> ($past(arr_wdata) & ~old_q) == 8'h00)
    else $error("program raised a cleared bit");
  a_erase_fill_walk: assert property (arr_we && $past(arr_we)
    |-> arr_wdata == 8'hff && arr_addr == $past(arr_addr) + 18'h00001)
    else $error("erase walk wrong data or address");
  a_we_needs_busy: assert property (arr_we |-> busy)
    else $error("array write while idle");
  a_done_idle: assert property ($fell(arr_we) |-> !busy)
    else $error("busy stayed after last array write");
  a_status_no_array: assert property (cmd_rd && busy |=> !arr_rd)
    else $error("array read while busy");
endmodule // flash_status_checker

bind flash_erase_program_status flash_status_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .rd_valid(rd_valid), .busy(busy), .arr_rd(arr_rd), .arr_we(arr_we),
  .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata)
);

// file: testbench/array_mem_model.sv
`timescale 1ns/1ns
module array_mem_model (
  input  wire logic                             clk_sys,
  input  wire logic                             arr_rd,
  input  wire logic                             arr_we,
  input  wire logic [flash_cmd_pkg::ADDR_W-1:0] arr_addr,
  input  wire logic [flash_cmd_pkg::DATA_W-1:0] arr_wdata,
  output logic      [flash_cmd_pkg::DATA_W-1:0] arr_rdata
);
  logic [7:0] mem [0:(1<<flash_cmd_pkg::ADDR_W)-1];
  initial begin
    for (int i = 0; i < (1 << flash_cmd_pkg::ADDR_W); i++) mem[i] = 8'hff;
  end
  // Data good only in the cycle after the strobe; toggling exposes stale use
  always @(posedge clk_sys) begin
    if (arr_we) mem[arr_addr] <= arr_wdata;
    if (arr_rd) arr_rdata <= mem[arr_addr];
    else arr_rdata <= ~arr_rdata;
  end
endmodule // array_mem_model

// file: testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam logic [7:0] MFR_CODE = 8'h6b; // Arbitrary value
  localparam logic [7:0] DEV_CODE = 8'h94; // Arbitrary value
  logic        clk_sys, rstn, cmd_wr, cmd_rd, rd_valid, arr_rd, arr_we, busy;
  logic [17:0] cmd_addr, arr_addr, a;
  logic [7:0]  cmd_wdata, rd_data, arr_wdata, arr_rdata, d1, d2;
  logic [6:0]  lock_bits;
  logic        top_boot_lock_pin_n, write_protect_pin_n;
  logic [7:0]  exp_q [$];
  int          bad_count, total_checks;
  logic [7:0]  pt_op [5] = '{8'h40, 8'h10, 8'h21, 8'h20, 8'h21};
  logic [17:0] pt_ad [5] = '{18'h00200, 18'h00200, 18'h3c000, 18'h3a000, 18'h10000};
  logic [6:0]  pt_lk [5] = '{7'h01, 7'h00, 7'h00, 7'h08, 7'h02};
  logic [1:0]  pt_pn [5] = '{2'b11, 2'b10, 2'b01, 2'b11, 2'b11};
  logic [7:0]  pt_st [5] = '{8'h92, 8'h92, 8'ha2, 8'ha2, 8'ha2};

  flash_erase_program_status #(.PROG_CYCLES(4), .MFR_ID(MFR_CODE), .DEV_ID(DEV_CODE)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .lock_bits(lock_bits),
    .top_boot_lock_pin_n(top_boot_lock_pin_n), .write_protect_pin_n(write_protect_pin_n),
    .arr_rd(arr_rd), .arr_we(arr_we), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_rdata(arr_rdata), .busy(busy));
  array_mem_model u_mem (.clk_sys(clk_sys), .arr_rd(arr_rd), .arr_we(arr_we),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));

  always #2 clk_sys = ~clk_sys;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic wr(input logic [17:0] ad, input logic [7:0] dt);
    @(negedge clk_sys);
    cmd_wr = 1'b1;
    cmd_addr = ad;
    cmd_wdata = dt;
    @(negedge clk_sys);
    cmd_wr = 1'b0;
  endtask
  task automatic rd(input logic [17:0] ad, input logic [7:0] exp);
    int n;
    exp_q.push_back(exp);
    @(negedge clk_sys);
    cmd_rd = 1'b1;
    cmd_addr = ad;
    @(negedge clk_sys);
    cmd_rd = 1'b0;
    n = 0;
    while (exp_q.size() != 0) begin
      if (n == 10) give_up();
      @(negedge clk_sys);
      n++;
    end
  endtask
  // Busy must already be up one cycle after the second command cycle
  task automatic wait_idle();
    int n;
    @(negedge clk_sys);
    check({7'h00, busy}, 8'h01);
    n = 0;
    while (busy !== 1'b0) begin
      if (n == 70000) give_up();
      @(negedge clk_sys);
      n++;
    end
  endtask

  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check({7'h00, rd_valid}, 8'h00);
      else check(rd_data, exp_q.pop_front());
    end
  end

  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_addr = '0;
    cmd_wdata = '0;
    lock_bits = '0;
    {top_boot_lock_pin_n, write_protect_pin_n} = 2'b11;
    bad_count = 0;
    total_checks = 0;
    void'($urandom(32'h874e431c));
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1'b1;
    wr(18'h00000, flash_cmd_pkg::OP_READ_STATUS);
    rd(18'h12345, 8'h80);
    wr(18'h00000, flash_cmd_pkg::OP_READ_ID);
    rd(flash_cmd_pkg::ID_ADDR_MFR, MFR_CODE);
    rd(flash_cmd_pkg::ID_ADDR_DEV, DEV_CODE);
    rd(18'h00002, flash_cmd_pkg::ID_UNMAPPED);
    wr(18'h00000, flash_cmd_pkg::OP_READ_ARRAY);
    rd(18'h00001, 8'hff);
    $display("Test status and identification done");
    a = 18'h00400 + 18'($urandom_range(0, 1023));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    wr(a, flash_cmd_pkg::OP_PROG_A);
    wr(a, d1);
    wait_idle();
    rd(a, 8'h80);
    wr(a, flash_cmd_pkg::OP_PROG_B);
    wr(a, d2);
    wait_idle();
    wr(a, flash_cmd_pkg::OP_READ_ARRAY);
    rd(a, d1 & d2);
    wr(18'h10000, flash_cmd_pkg::OP_ERASE);
    wr(18'h10000, 8'h00);
    rd(18'h10000, 8'hb0);
    $display("Test program and sequence error done");
    for (int i = 0; i < 5; i++) begin
      wr(18'h00000, flash_cmd_pkg::OP_CLEAR_STATUS);
      lock_bits = pt_lk[i];
      {top_boot_lock_pin_n, write_protect_pin_n} = pt_pn[i];
      wr(pt_ad[i], pt_op[i]);
      wr(pt_ad[i], pt_st[i][5] ? flash_cmd_pkg::OP_CONFIRM : 8'($urandom));
      @(negedge clk_sys);
      check({7'h00, busy}, 8'h00);
      rd(pt_ad[i], pt_st[i]);
      lock_bits = '0;
      {top_boot_lock_pin_n, write_protect_pin_n} = 2'b11;
      rd(pt_ad[i], pt_st[i]);
    end
    wr(18'h00000, flash_cmd_pkg::OP_CLEAR_STATUS);
    wr(18'h00000, flash_cmd_pkg::OP_READ_STATUS);
    rd(18'h00000, 8'h80);
    wr(18'h00000, flash_cmd_pkg::OP_READ_ARRAY);
    rd(18'h00200, 8'hff);
    $display("Test protection done");
    foreach (pt_ad[i]) begin
      a = (i == 0) ? 18'h3a010 : (i == 1) ? 18'h38010 : 18'h2ffff;
      if (i < 3) wr(a, flash_cmd_pkg::OP_PROG_A);
      if (i < 3) wr(a, 8'h00);
      if (i < 3) wait_idle();
    end
    wr(18'h3a123, flash_cmd_pkg::OP_ERASE);
    wr(18'h3a123, flash_cmd_pkg::OP_CONFIRM);
    wr(18'h00000, flash_cmd_pkg::OP_READ_ARRAY);
    rd(18'h3a010, 8'h00);
    wait_idle();
    rd(18'h00000, 8'h80);
    wr(18'h00000, flash_cmd_pkg::OP_READ_ARRAY);
    rd(18'h3a010, 8'hff);
    rd(18'h38010, 8'h00);
    wr(18'h3a000, flash_cmd_pkg::OP_UNIFORM);
    wr(18'h3a000, flash_cmd_pkg::OP_CONFIRM);
    wait_idle();
    wr(18'h00000, flash_cmd_pkg::OP_READ_ARRAY);
    rd(18'h38010, 8'hff);
    rd(18'h2ffff, 8'h00);
    $display("Test erase done");
    tally_and_finish();
  end
endmodule // testbench
